// ==== dwr_regs.svh ====
// What this block does
// - Two wiper settings of 256 positions each, sharing one nonvolatile write engine between them.
// - Each wiper position comes only from its own 8-bit volatile position register.
// - Position code zero puts the wiper at the tap nearest the low terminal.
// - Rising codes move the wiper one tap per code toward the high terminal.
// - The stored power-on value of each wiper survives power removal.
// - At power-up each stored value is copied into its position register.
// - Until reprogrammed, the stored power-on value is the mid-scale factory code.
// - The volatile-only select bit decides whether a wiper write also updates storage.
// - A volatile-only write moves the wiper at once and leaves storage untouched.
// - All registers are read and written by an external bus master.
// - A written wiper reaches its new position within 600 ns.
// - Power-up recall and standby entry complete within 100 us.
// - A nonvolatile write takes 20 ms; the master waits before relying on it.
// - A shutdown command puts the high terminal in high impedance while active.
`ifndef DWR_REGS_SVH
`define DWR_REGS_SVH

// Register byte offsets
`define DWR_OFS_WIPER_A 12'h000
`define DWR_OFS_WIPER_B 12'h004
`define DWR_OFS_STORE_A 12'h008
`define DWR_OFS_STORE_B 12'h00C
`define DWR_OFS_CTRL 12'h010

// Access control fields
`define DWR_CTRL_VOLATILE_ONLY 0
`define DWR_CTRL_SHDN_A 1
`define DWR_CTRL_SHDN_B 2
`define DWR_CTRL_NV_BUSY 3
`define DWR_CTRL_NV_DROP 4

// Reset and factory values
`define DWR_FACTORY_CODE 8'h80
`define DWR_CTRL_RESET 3'h0

// Timing
`define DWR_CLK_NS 100
`define DWR_RECALL_US 35
`define DWR_RECALL_CYC ((`DWR_RECALL_US * 1000) / `DWR_CLK_NS)
`define DWR_NV_WRITE_MS 20
`define DWR_NV_WRITE_CYC ((`DWR_NV_WRITE_MS * 1000000) / `DWR_CLK_NS)

`endif

// ==== dwr_pkg.sv ====
package dwr_pkg;
	typedef enum logic [0:0] {ST_RECALL, ST_RUN} dwr_state_t;
	typedef logic [7:0] dwr_code_t;
endpackage

// ==== dwr_wiper_bank.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dwr_regs.svh"
module dwr_wiper_bank
	import dwr_pkg::*;
#(
	parameter int unsigned NV_WRITE_CYCLES = `DWR_NV_WRITE_CYC
)
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Factory programming of the nonvolatile store
	input wire logic i_nv_factory,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Wiper side
	output logic [7:0] o_wiper_a,
	output logic [7:0] o_wiper_b,
	output logic o_h_hiz_a,
	output logic o_h_hiz_b,
	output logic o_standby,
	output logic o_nv_busy
);
	localparam logic [8:0] RECALL_LAST = 9'(`DWR_RECALL_CYC - 1);
	localparam logic [17:0] NV_LAST = 18'(NV_WRITE_CYCLES - 1);

	dwr_state_t state_q;
	logic [2:0] ctrl_q;
	logic busy_q;
	logic drop_q;
	logic pend_sel_q;
	dwr_code_t pend_val_q;
	logic recall_end;
	logic nv_done;
	dwr_code_t wiper_a;
	dwr_code_t wiper_b;
	dwr_code_t nv_a;
	dwr_code_t nv_b;

	// Address decode
	wire logic ready = (state_q == ST_RUN);
	wire logic recalling = (state_q == ST_RECALL);
	wire logic acc = i_psel && i_penable && ready;
	wire logic wr = acc && i_pwrite;
	wire logic hit_wa = (i_paddr == `DWR_OFS_WIPER_A);
	wire logic hit_wb = (i_paddr == `DWR_OFS_WIPER_B);
	wire logic hit_sa = (i_paddr == `DWR_OFS_STORE_A);
	wire logic hit_sb = (i_paddr == `DWR_OFS_STORE_B);
	wire logic hit_ctrl = (i_paddr == `DWR_OFS_CTRL);
	wire logic hit_any = hit_wa || hit_wb || hit_sa || hit_sb || hit_ctrl;
	wire dwr_code_t wdat = i_pwdata[7:0];
	wire logic volatile_only_select = ctrl_q[`DWR_CTRL_VOLATILE_ONLY];
	wire logic wr_wa = wr && hit_wa;
	wire logic wr_wb = wr && hit_wb;
	wire logic wr_ctrl = wr && hit_ctrl;

	// Nonvolatile write requests: store writes always, wiper writes unless volatile-only
	wire logic nv_req_a = wr && (hit_sa || (hit_wa && !volatile_only_select));
	wire logic nv_req_b = wr && (hit_sb || (hit_wb && !volatile_only_select));
	wire logic nv_req = nv_req_a || nv_req_b;
	wire logic nv_start = nv_req && !busy_q;
	wire logic drop_set = nv_req && busy_q;
	wire logic drop_clr = wr_ctrl && i_pwdata[`DWR_CTRL_NV_DROP];
	wire logic commit_a = nv_done && !pend_sel_q;
	wire logic commit_b = nv_done && pend_sel_q;

	// Read words
	wire logic [31:0] word_wa = {24'h0000_00, wiper_a};
	wire logic [31:0] word_wb = {24'h0000_00, wiper_b};
	wire logic [31:0] word_sa = {24'h0000_00, nv_a};
	wire logic [31:0] word_sb = {24'h0000_00, nv_b};
	wire logic [31:0] word_ctrl = {27'h000_0000, drop_q, busy_q, ctrl_q};

	assign o_pready = ready;
	assign o_pslverr = acc && !hit_any;
	assign o_prdata = hit_wa ? word_wa :
		hit_wb ? word_wb :
		hit_sa ? word_sa :
		hit_sb ? word_sb :
		hit_ctrl ? word_ctrl :
		32'h0000_0000;

	// Wiper tap follows the code directly, zero at the low end, one tap per code
	assign o_wiper_a = wiper_a;
	assign o_wiper_b = wiper_b;
	assign o_h_hiz_a = ctrl_q[`DWR_CTRL_SHDN_A];
	assign o_h_hiz_b = ctrl_q[`DWR_CTRL_SHDN_B];
	assign o_standby = ready;
	assign o_nv_busy = busy_q;

	// Power-up recall timer
	dwr_step_timer #(
		.WIDTH(9),
		.LAST(RECALL_LAST)
	) recall_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_restart(1'b0),
		.i_run(recalling),
		.o_last(recall_end)
	);

	// Nonvolatile write timer
	dwr_step_timer #(
		.WIDTH(18),
		.LAST(NV_LAST)
	) nv_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_restart(nv_start),
		.i_run(busy_q),
		.o_last(nv_done)
	);

	// Wiper A registers
	dwr_wiper_slot slot_a (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_recall(recall_end),
		.i_nv_factory(i_nv_factory),
		.i_write(wr_wa),
		.i_code(wdat),
		.i_commit(commit_a),
		.i_commit_code(pend_val_q),
		.o_live(wiper_a),
		.o_stored(nv_a)
	);

	// Wiper B registers
	dwr_wiper_slot slot_b (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_recall(recall_end),
		.i_nv_factory(i_nv_factory),
		.i_write(wr_wb),
		.i_code(wdat),
		.i_commit(commit_b),
		.i_commit_code(pend_val_q),
		.o_live(wiper_b),
		.o_stored(nv_b)
	);

	// Recall state
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= ST_RECALL;
		end
		else if (recall_end)
		begin
			state_q <= ST_RUN;
		end
	end

	// Access control register
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			ctrl_q <= `DWR_CTRL_RESET;
		end
		else if (wr_ctrl)
		begin
			ctrl_q <= i_pwdata[2:0];
		end
	end

	// Nonvolatile write in flight; a request while busy is dropped
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			busy_q <= 1'b0;
			pend_sel_q <= 1'b0;
			pend_val_q <= 8'h00;
		end
		else if (nv_start)
		begin
			busy_q <= 1'b1;
			pend_sel_q <= nv_req_b;
			pend_val_q <= wdat;
		end
		else if (nv_done)
		begin
			busy_q <= 1'b0;
		end
	end

	// Drop flag: a drop in the clearing cycle keeps it set
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			drop_q <= 1'b0;
		end
		else if (drop_set)
		begin
			drop_q <= 1'b1;
		end
		else if (drop_clr)
		begin
			drop_q <= 1'b0;
		end
	end
endmodule

module dwr_step_timer
	import dwr_pkg::*;
#(
	parameter int unsigned WIDTH = 9,
	parameter logic [WIDTH-1:0] LAST = '0
)
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Control
	input wire logic i_restart,
	input wire logic i_run,
	// Status
	output logic o_last
);
	localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// Restart wins over counting
	assign cnt_d = i_restart ? '0 : (i_run ? cnt_q + ONE : cnt_q);
	assign o_last = i_run && (cnt_q == LAST);

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_d;
		end
	end
endmodule

module dwr_wiper_slot
	import dwr_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Power-up recall and factory programming
	input wire logic i_recall,
	input wire logic i_nv_factory,
	// Host write to the live position
	input wire logic i_write,
	input wire dwr_code_t i_code,
	// Commit of a finished nonvolatile write
	input wire logic i_commit,
	input wire dwr_code_t i_commit_code,
	// Register contents
	output var dwr_code_t o_live,
	output var dwr_code_t o_stored
);
	dwr_code_t live_q;
	dwr_code_t stored_q;

	// Live position, reloaded from storage when recall ends
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			live_q <= `DWR_FACTORY_CODE;
		end
		else if (i_recall)
		begin
			live_q <= stored_q;
		end
		else if (i_write)
		begin
			live_q <= i_code;
		end
	end

	// Stored value: no reset, so it survives power loss
	always_ff @(posedge i_clk_sys)
	begin
		if (i_nv_factory)
		begin
			stored_q <= `DWR_FACTORY_CODE;
		end
		else if (i_commit)
		begin
			stored_q <= i_commit_code;
		end
	end

	assign o_live = live_q;
	assign o_stored = stored_q;
endmodule
`default_nettype wire

// ==== dwr_apb_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module dwr_apb_host
(
	// Bus answer
	input wire logic i_clk_sys,
	input wire logic i_pready,
	input wire logic [31:0] i_prdata,
	// Bus request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [11:0] o_paddr,
	output logic [31:0] o_pwdata
);
	initial
		{o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
	// One transfer, held until ready; data line shows junk once released
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_clk_sys);
		o_psel <= 1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk_sys);
		o_penable <= 1;
		do
			@(posedge i_clk_sys);
		while (i_pready !== 1);
		q = i_prdata;
		o_psel <= 0;
		o_penable <= 0;
		o_pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== dwr_wiper_bank_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module dwr_wiper_bank_checker
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [7:0] o_wiper_a,
	input wire logic [7:0] o_wiper_b,
	input wire logic o_h_hiz_a,
	input wire logic o_standby,
	input wire logic o_nv_busy
);
	wire wr = i_psel & i_penable & o_pready & i_pwrite;
	wire wa = wr && i_paddr == 12'h000;
	wire wb = wr && i_paddr == 12'h004;
	logic volatile_only_q;
	logic [10:0] recall_cnt_q;
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
			volatile_only_q <= 0;
		else if (wr && i_paddr == 12'h010)
			volatile_only_q <= i_pwdata[0];
	always_ff @(posedge i_clk_sys or posedge i_rst)
		if (i_rst)
			recall_cnt_q <= 11'h000;
		else if (!o_standby && recall_cnt_q != 11'h7ff)
			recall_cnt_q <= recall_cnt_q + 11'h001;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	new_a_a: assert property (wa |=> o_wiper_a == $past(i_pwdata[7:0]))
		else $error("wiper a not loaded");
	new_b_a: assert property (wb |=> o_wiper_b == $past(i_pwdata[7:0]))
		else $error("wiper b not loaded");
	hold_a_a: assert property (o_pready && !wa |=> $stable(o_wiper_a))
		else $error("wiper a moved");
	hold_b_a: assert property (o_pready && !wb |=> $stable(o_wiper_b))
		else $error("wiper b moved");
	hiz_a_a: assert property (wr && i_paddr == 12'h010 |=> o_h_hiz_a == $past(i_pwdata[1]))
		else $error("shutdown a wrong");
	store_go_a: assert property ((wa || wb) && !volatile_only_q && !o_nv_busy |=> o_nv_busy)
		else $error("store write missing");
	vol_only_a: assert property ((wa || wb) && volatile_only_q && !o_nv_busy |=> !o_nv_busy)
		else $error("store written");
	recall_time_a: assert property (recall_cnt_q < 11'h3e8)
		else $error("recall too slow");
	slave_error_a: assert property (i_psel && i_penable && o_pready |->
		o_pslverr == !(i_paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}))
		else $error("slave error wrong");
endmodule
bind dwr_wiper_bank dwr_wiper_bank_checker chk (.i_clk_sys, .i_rst, .i_psel, .i_penable,
	.i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .o_wiper_a, .o_wiper_b, .o_h_hiz_a,
	.o_standby, .o_nv_busy);
`default_nettype wire

// ==== dwr_wiper_bank_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module dwr_wiper_bank_bench;
	logic clk, rst, fac, sel, en, wr, rdy, err, hza, hzb, sb, bsy;
	logic [11:0] adr;
	logic [31:0] wd, rdat, q;
	logic [7:0] wa, wb;
	int n_fail, num_checks;
	dwr_wiper_bank #(.NV_WRITE_CYCLES(20)) uut (.i_clk_sys(clk), .i_rst(rst), .i_nv_factory(fac),
		.i_psel(sel), .i_penable(en), .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd),
		.o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .o_wiper_a(wa), .o_wiper_b(wb),
		.o_h_hiz_a(hza), .o_h_hiz_b(hzb), .o_standby(sb), .o_nv_busy(bsy));
	dwr_apb_host h (.i_clk_sys(clk), .i_pready(rdy), .i_prdata(rdat), .o_psel(sel),
		.o_penable(en), .o_pwrite(wr), .o_paddr(adr), .o_pwdata(wd));
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		h.xfer(0, a, 0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		#400000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		rst = 1;
		fac = 1;
		repeat (5) @(posedge clk);
		rst <= 0;
		fac <= 0;
		rd(12'h000, 32'h0000_0080);
		chk("standby", 32'h0000_0001, sb);
		rd(12'h008, 32'h0000_0080);
		$display("recall done");
		h.xfer(1, 12'h010, 32'h0000_0001, q);
		h.xfer(1, 12'h000, 32'h0000_0000, q);
		@(negedge clk);
		chk("wiper b", 32'h0000_0080, wb);
		chk("wiper a", 32'h0000_0000, wa);
		rd(12'h010, 32'h0000_0001);
		rd(12'h008, 32'h0000_0080);
		$display("volatile done");
		h.xfer(1, 12'h010, 32'h0000_0000, q);
		h.xfer(1, 12'h004, 32'h0000_00ff, q);
		h.xfer(1, 12'h008, 32'h0000_0022, q);
		@(negedge clk);
		chk("busy pin", 32'h0000_0001, bsy);
		rd(12'h010, 32'h0000_0018);
		repeat (25) @(posedge clk);
		rd(12'h010, 32'h0000_0010);
		h.xfer(1, 12'h010, 32'h0000_0010, q);
		rd(12'h010, 32'h0000_0000);
		rd(12'h00c, 32'h0000_00ff);
		rd(12'h008, 32'h0000_0080);
		rst <= 1;
		repeat (5) @(posedge clk);
		rst <= 0;
		rd(12'h004, 32'h0000_00ff);
		rd(12'h000, 32'h0000_0080);
		$display("storage done");
		h.xfer(1, 12'h010, 32'h0000_0006, q);
		@(negedge clk);
		chk("high z", 32'h0000_0003, {hzb, hza});
		rd(12'h014, 32'h0000_0000);
		$display("shutdown done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
